// ### hdl/timer_set_pkg.sv
package timer_set_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_TIMERS = 6;
  localparam int MAX_CH     = 4;
  localparam int MAX_W      = 32;
  localparam int PSC_W      = 16;
  localparam int DT_W       = 8;
  localparam int SEL_W      = 3;
  localparam int MODE_W     = 2;
  localparam int SLV_W      = 3;
  localparam int CHM_W      = 2;

  // ----------------------------------------------------------------
  // modes
  // ----------------------------------------------------------------
  typedef enum logic [MODE_W-1:0] {cm_up, cm_down, cm_center} cnt_mode_type;
  typedef enum logic [CHM_W-1:0] {chm_off, chm_capture, chm_toggle, chm_pwm} ch_mode_type;
  typedef enum logic [SLV_W-1:0] {
    sm_free, sm_reset, sm_trig_start, sm_ext_clock, sm_encoder, sm_hall
  } slave_mode_type;
  typedef enum logic {dir_up, dir_down} dir_type;

  // ----------------------------------------------------------------
  // per-timer shape, index order:
  // advanced_pwm_timer, wide_quad_timer, narrow_quad_timer,
  // single_channel_plain_timer, single_channel_comp_timer_a, _b
  // ----------------------------------------------------------------
  localparam int TIM_CNT_W  [NUM_TIMERS] = '{16, 32, 16, 16, 16, 16};
  localparam int TIM_NCH    [NUM_TIMERS] = '{4, 4, 4, 1, 1, 1};
  localparam int TIM_UPDOWN [NUM_TIMERS] = '{1, 1, 1, 0, 0, 0};
  localparam int TIM_NCOMP  [NUM_TIMERS] = '{3, 0, 0, 0, 1, 1};
  localparam int TIM_DMA    [NUM_TIMERS] = '{1, 1, 1, 0, 1, 1};
  localparam int TIM_SENSOR [NUM_TIMERS] = '{0, 1, 1, 0, 0, 0};

endpackage

// ### hdl/out_stage_if.sv
`timescale 1ns/1ns
`default_nettype none
interface out_stage_if;
  import timer_set_pkg::*;
  logic            ref_lvl;
  logic [DT_W-1:0] dead;
  logic            out;
  logic            out_n;
  modport core  (output ref_lvl, output dead, input out, input out_n);
  modport stage (input ref_lvl, input dead, output out, output out_n);
endinterface // out_stage_if
`default_nettype wire

// ### hdl/ch_out_stage.sv
`timescale 1ns/1ns
`default_nettype none
module ch_out_stage
  import timer_set_pkg::*;
#(
  parameter bit HAS_COMP = 1'b0
) (
  input wire logic   ref_clk_i,
  input wire logic   reset_i,
  out_stage_if.stage stg
);

  logic            ref_d_r,  ref_d_nxt;
  logic [DT_W-1:0] dt_r,     dt_nxt;
  logic            out_r,    out_nxt;
  logic            out_n_r,  out_n_nxt;
  logic            quiet;

  // ----------------------------------------------------------------
  // dead time: both outputs stay low for dead cycles after each edge
  // ----------------------------------------------------------------
  always_comb begin
    ref_d_nxt = stg.ref_lvl;
    if (stg.ref_lvl != ref_d_r) begin
      dt_nxt = stg.dead;
    end else if (dt_r != '0) begin
      dt_nxt = dt_r - DT_W'(1);
    end else begin
      dt_nxt = '0;
    end
    quiet     = (dt_nxt == '0);
    out_nxt   = stg.ref_lvl & quiet;
    out_n_nxt = HAS_COMP & ~stg.ref_lvl & quiet;
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ref_d_r <= 1'b0;
      dt_r    <= '0;
      out_r   <= 1'b0;
      out_n_r <= 1'b0;
    end else begin
      ref_d_r <= ref_d_nxt;
      dt_r    <= dt_nxt;
      out_r   <= out_nxt;
      out_n_r <= out_n_nxt;
    end
  end

  assign stg.out   = out_r;
  assign stg.out_n = out_n_r;

endmodule // ch_out_stage
`default_nettype wire

// ### hdl/multi_channel_timer_set.sv
`timescale 1ns/1ns
`default_nettype none
module multi_channel_timer_set
  import timer_set_pkg::*;
(
  input  wire logic                                          ref_clk_i,
  input  wire logic                                          reset_i,
  input  wire logic                                          dbg_halt_i,
  input  wire logic [NUM_TIMERS-1:0]                         enable_i,
  input  wire logic [NUM_TIMERS-1:0]                         freeze_en_i,
  input  wire logic [NUM_TIMERS-1:0]                         one_pulse_i,
  input  wire logic [NUM_TIMERS-1:0][MODE_W-1:0]             count_mode_i,
  input  wire logic [NUM_TIMERS-1:0][SLV_W-1:0]              slave_mode_i,
  input  wire logic [NUM_TIMERS-1:0][SEL_W-1:0]              trig_sel_i,
  input  wire logic [NUM_TIMERS-1:0][PSC_W-1:0]              prescale_i,
  input  wire logic [NUM_TIMERS-1:0][MAX_W-1:0]              reload_i,
  input  wire logic [NUM_TIMERS-1:0][MAX_CH-1:0][MAX_W-1:0]  compare_i,
  input  wire logic [NUM_TIMERS-1:0][MAX_CH-1:0][CHM_W-1:0]  ch_mode_i,
  input  wire logic [NUM_TIMERS-1:0][DT_W-1:0]               dead_time_i,
  input  wire logic [NUM_TIMERS-1:0][MAX_CH-1:0]             ch_pin_i,
  output wire logic [NUM_TIMERS-1:0][MAX_CH-1:0]             ch_out_o,
  output wire logic [NUM_TIMERS-1:0][MAX_CH-1:0]             ch_out_n_o,
  output wire logic [NUM_TIMERS-1:0][MAX_CH-1:0][MAX_W-1:0]  capture_o,
  output wire logic [NUM_TIMERS-1:0][MAX_W-1:0]              count_o,
  output wire logic [NUM_TIMERS-1:0]                         dir_down_o,
  output wire logic [NUM_TIMERS-1:0]                         update_o,
  output wire logic [NUM_TIMERS-1:0]                         dma_req_o
);

  logic [NUM_TIMERS-1:0] upd_w;

  for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_tim
    localparam int               W     = TIM_CNT_W[t];
    localparam int               NCH   = TIM_NCH[t];
    localparam bit               UPDN  = TIM_UPDOWN[t] != 0;
    localparam int               NCOMP = TIM_NCOMP[t];
    localparam bit               DMA   = TIM_DMA[t] != 0;
    localparam bit               SENS  = TIM_SENSOR[t] != 0;
    localparam logic [MAX_W-1:0] MASK  = {MAX_W{1'b1}} >> (MAX_W - W);

    // --------------------------------------------------------------
    // pin synchronisers
    // --------------------------------------------------------------
    logic [MAX_CH-1:0] pin_s1_r;
    logic [MAX_CH-1:0] pin_s2_r;
    logic [MAX_CH-1:0] pin_d_r;

    always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
        pin_s1_r <= '0;
        pin_s2_r <= '0;
        pin_d_r  <= '0;
      end else begin
        pin_s1_r <= ch_pin_i[t];
        pin_s2_r <= pin_s1_r;
        pin_d_r  <= pin_s2_r;
      end
    end

    // --------------------------------------------------------------
    // counter and channels
    // --------------------------------------------------------------
    logic [PSC_W-1:0]  psc_r, psc_nxt;
    logic [MAX_W-1:0]  cnt_r, cnt_nxt;
    dir_type           dir_r, dir_nxt;
    logic              run_r, run_nxt;
    logic              en_d_r, en_d_nxt;
    logic              upd_r, upd_nxt;
    logic              dma_r, dma_nxt;
    logic [MAX_W-1:0]  cap_r   [MAX_CH];
    logic [MAX_W-1:0]  cap_nxt [MAX_CH];
    logic [MAX_CH-1:0] ref_r, ref_nxt;
    logic [MAX_CH-1:0] ch_ev;
    logic [MAX_W-1:0]  arr;
    logic              trig, freeze, go, step, psc_tick, a_edge, hall_chg, down;
    cnt_mode_type      mode;
    slave_mode_type    smode;
    ch_mode_type       chm;

    assign arr  = reload_i[t] & MASK;
    assign trig = (trig_sel_i[t] < SEL_W'(NUM_TIMERS)) ? upd_w[trig_sel_i[t]] : 1'b0;

    always_comb begin
      // single-channel timers forced to count up
      mode  = UPDN ? cnt_mode_type'(count_mode_i[t]) : cm_up;
      smode = slave_mode_type'(slave_mode_i[t]);
      if (!SENS && (smode == sm_encoder || smode == sm_hall)) begin
        smode = sm_free;
      end
      psc_nxt  = psc_r;
      cnt_nxt  = cnt_r;
      dir_nxt  = dir_r;
      run_nxt  = run_r;
      en_d_nxt = enable_i[t];
      upd_nxt  = 1'b0;
      ch_ev    = '0;
      ref_nxt  = ref_r;
      for (int c = 0; c < MAX_CH; c++) begin
        cap_nxt[c] = cap_r[c];
      end
      freeze   = dbg_halt_i & freeze_en_i[t];
      go       = run_r & ~freeze;
      // a lowered prescale must not send the count the long way round
      psc_tick = (psc_r >= prescale_i[t]);
      a_edge   = pin_s2_r[0] ^ pin_d_r[0];
      hall_chg = (^pin_s2_r[2:0]) ^ (^pin_d_r[2:0]);
      if (enable_i[t] && !en_d_r && smode != sm_trig_start) begin
        run_nxt = 1'b1;
      end
      if (enable_i[t] && trig && smode == sm_trig_start) begin
        run_nxt = 1'b1;
      end
      unique case (smode)
        sm_ext_clock: step = trig;
        sm_encoder:   step = a_edge;
        default:      step = psc_tick;
      endcase
      // prescaler divides by prescale + 1
      if (go && smode != sm_ext_clock && smode != sm_encoder) begin
        psc_nxt = psc_tick ? '0 : psc_r + PSC_W'(1);
      end
      if (smode == sm_encoder) begin
        down = (pin_s2_r[0] == pin_s2_r[1]);
      end else begin
        down = (mode == cm_down) || (mode == cm_center && dir_r == dir_down);
      end
      if (mode != cm_center || smode == sm_encoder) begin
        dir_nxt = down ? dir_down : dir_up;
      end
      if (go && step) begin
        if (!down) begin
          if (cnt_r >= arr) begin
            upd_nxt = 1'b1;
            // center mode turns at the top
            if (mode == cm_center && smode != sm_encoder) begin
              cnt_nxt = (arr == '0) ? '0 : arr - MAX_W'(1);
              dir_nxt = dir_down;
            end else begin
              cnt_nxt = '0;
            end
          end else begin
            cnt_nxt = cnt_r + MAX_W'(1);
          end
        end else if (cnt_r == '0) begin
          upd_nxt = 1'b1;
          if (mode == cm_center && smode != sm_encoder) begin
            cnt_nxt = (arr == '0) ? '0 : MAX_W'(1);
            dir_nxt = dir_up;
          end else begin
            cnt_nxt = arr;
          end
        end else if (cnt_r > arr) begin
          cnt_nxt = arr;
        end else begin
          cnt_nxt = cnt_r - MAX_W'(1);
        end
      end
      for (int c = 0; c < MAX_CH; c++) begin
        chm = (c < NCH) ? ch_mode_type'(ch_mode_i[t][c]) : chm_off;
        unique case (chm)
          chm_capture: begin
            ref_nxt[c] = 1'b0;
            if (pin_s2_r[c] && !pin_d_r[c]) begin
              cap_nxt[c] = cnt_r;
              ch_ev[c]   = 1'b1;
            end
          end
          chm_toggle: begin
            if (go && step && cnt_r == (compare_i[t][c] & MASK)) begin
              ref_nxt[c] = ~ref_r[c];
              ch_ev[c]   = 1'b1;
            end
          end
          // compare zero gives 0, above reload gives 100
          chm_pwm: ref_nxt[c] = (cnt_r < (compare_i[t][c] & MASK));
          chm_off: ref_nxt[c] = 1'b0;
        endcase
      end
      if (smode == sm_hall && go && hall_chg) begin
        cap_nxt[0] = cnt_r;
        ch_ev[0]   = 1'b1;
        cnt_nxt    = '0;
        psc_nxt    = '0;
      end
      if (smode == sm_reset && trig) begin
        cnt_nxt = '0;
        psc_nxt = '0;
        dir_nxt = dir_up;
        upd_nxt = 1'b1;
      end
      if (upd_nxt && one_pulse_i[t]) begin
        run_nxt = 1'b0;
      end
      if (!enable_i[t]) begin
        run_nxt = 1'b0;
      end
      // plain timer has no DMA request
      dma_nxt = DMA & (upd_nxt | (|ch_ev));
    end

    always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
        psc_r  <= '0;
        cnt_r  <= '0;
        dir_r  <= dir_up;
        run_r  <= 1'b0;
        en_d_r <= 1'b0;
        upd_r  <= 1'b0;
        dma_r  <= 1'b0;
        ref_r  <= '0;
        for (int c = 0; c < MAX_CH; c++) begin
          cap_r[c] <= '0;
        end
      end else begin
        psc_r  <= psc_nxt;
        cnt_r  <= cnt_nxt;
        dir_r  <= dir_nxt;
        run_r  <= run_nxt;
        en_d_r <= en_d_nxt;
        upd_r  <= upd_nxt;
        dma_r  <= dma_nxt;
        ref_r  <= ref_nxt;
        for (int c = 0; c < MAX_CH; c++) begin
          cap_r[c] <= cap_nxt[c];
        end
      end
    end

    // --------------------------------------------------------------
    // outputs; update pulse doubles as link trigger
    // --------------------------------------------------------------
    assign upd_w[t]      = upd_r;
    assign update_o[t]   = upd_r;
    assign dma_req_o[t]  = dma_r;
    assign count_o[t]    = cnt_r;
    assign dir_down_o[t] = (dir_r == dir_down);

    for (genvar c = 0; c < MAX_CH; c++) begin : g_ch
      out_stage_if sif ();
      assign sif.ref_lvl       = ref_r[c];
      // dead time only on complementary channels
      assign sif.dead          = (c < NCOMP) ? dead_time_i[t] : '0;
      assign capture_o[t][c]   = cap_r[c];
      assign ch_out_o[t][c]    = sif.out;
      assign ch_out_n_o[t][c]  = sif.out_n;

      ch_out_stage #(
        .HAS_COMP (c < NCOMP)
      ) u_stage (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .stg       (sif.stage)
      );
    end
  end

endmodule // multi_channel_timer_set
`default_nettype wire

// ### tb/timer_set_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module timer_set_monitor
  import timer_set_pkg::*;
(
  input wire logic                               ref_clk_i,
  input wire logic                               reset_i,
  input wire logic                               dbg_halt_i,
  input wire logic [NUM_TIMERS-1:0]              enable_i,
  input wire logic [NUM_TIMERS-1:0]              freeze_en_i,
  input wire logic [NUM_TIMERS-1:0][MAX_CH-1:0]  ch_out_o,
  input wire logic [NUM_TIMERS-1:0][MAX_CH-1:0]  ch_out_n_o,
  input wire logic [NUM_TIMERS-1:0][MAX_W-1:0]   count_o,
  input wire logic [NUM_TIMERS-1:0]              dir_down_o,
  input wire logic [NUM_TIMERS-1:0]              update_o,
  input wire logic [NUM_TIMERS-1:0]              dma_req_o
);
  // ------------------------------
  // port relations
  // ------------------------------
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);

  AST_PLAIN_NO_DMA: assert property (dma_req_o[3] == 1'b0)
    else $error("dma request from plain timer");
  AST_UPDATE_DMA: assert property (((update_o & ~dma_req_o) & 6'h37) == 6'h00)
    else $error("update without dma request");
  AST_UP_ONLY: assert property (dir_down_o[5:3] == 3'h0)
    else $error("single-channel timer counting down");
  AST_NARROW: assert property ({count_o[0][31:16], count_o[2][31:16]} == 32'h0)
    else $error("16-bit counter above its width");
  AST_NO_COMP: assert property ({ch_out_n_o[3:1], ch_out_n_o[0][3]} == 13'h0)
    else $error("complement on a channel without one");
  // overlap here would short a half bridge
  AST_PAIR_EXCL: assert property ((ch_out_o[0][2:0] & ch_out_n_o[0][2:0]) == 3'h0)
    else $error("main and complement high together");
  AST_FREEZE: assert property (dbg_halt_i && freeze_en_i[0] |=> $stable(count_o[0]))
    else $error("counter moved while frozen");
  AST_UP_WRAP: assert property ($rose(update_o[3]) |-> count_o[3] == '0)
    else $error("update without wrap to zero");
  AST_IDLE: assert property (!enable_i[3] [*2] |=> $stable(count_o[3]))
    else $error("stopped counter moved");

  cover property (update_o[2] && dir_down_o[2]);
  cover property (dbg_halt_i && freeze_en_i[0]);
  cover property (ch_out_n_o[0][0]);
endmodule // timer_set_monitor

bind multi_channel_timer_set timer_set_monitor mon (
  .ref_clk_i, .reset_i, .dbg_halt_i, .enable_i, .freeze_en_i, .ch_out_o, .ch_out_n_o,
  .count_o, .dir_down_o, .update_o, .dma_req_o
);
`default_nettype wire

// ### tb/quad_encoder_model.sv
`timescale 1ns/1ns
`default_nettype none
module quad_encoder_model (
  input  wire logic ref_clk_i,
  input  wire logic step_i,
  input  wire logic back_i,
  output var  logic a_o,
  output var  logic b_o
);
  // ------------------------------
  // quadrature phase
  // ------------------------------
  logic [1:0] phase_r = 2'h0;
  logic [1:0] phase_nxt;
  // gray order: only one line moves per step, as on a real disc
  always_comb begin
    phase_nxt = phase_r;
    if (step_i) phase_nxt = back_i ? phase_r - 2'h1 : phase_r + 2'h1;
  end
  always_ff @(posedge ref_clk_i) begin
    phase_r <= phase_nxt;
  end
  assign a_o = ^phase_r;
  assign b_o = phase_r[1];
endmodule // quad_encoder_model
`default_nettype wire

// ### tb/multi_channel_timer_set_tb.sv
`timescale 1ns/1ns
`default_nettype none
module multi_channel_timer_set_tb;
  import timer_set_pkg::*;
  logic                              ref_clk_i = 1'b0, reset_i = 1'b1, dbg_halt_i = 1'b0;
  logic [NUM_TIMERS-1:0]             enable_i = '0, freeze_en_i = '0, one_pulse_i = '0;
  logic [NUM_TIMERS-1:0]             dir_down_o, update_o, dma_req_o;
  logic [NUM_TIMERS-1:0][MODE_W-1:0] count_mode_i = '0;
  logic [NUM_TIMERS-1:0][SLV_W-1:0]  slave_mode_i = '0;
  logic [NUM_TIMERS-1:0][SEL_W-1:0]  trig_sel_i = '1;
  logic [NUM_TIMERS-1:0][PSC_W-1:0]  prescale_i = '0;
  logic [NUM_TIMERS-1:0][MAX_W-1:0]  reload_i = '0, count_o, snap;
  logic [NUM_TIMERS-1:0][DT_W-1:0]   dead_time_i = '0;
  logic [NUM_TIMERS-1:0][MAX_CH-1:0] ch_pin_i, pin_rnd = '0, ch_out_o, ch_out_n_o;
  logic                              enc_a, enc_b, enc_step = 1'b0, enc_back = 1'b0;
  int unsigned                       n, hi_m [MAX_CH], hi_n [MAX_CH];
  int unsigned                       n_mismatch = 0, comparisons = 0;

  logic [NUM_TIMERS-1:0][MAX_CH-1:0][MAX_W-1:0] compare_i = '0, capture_o;
  logic [NUM_TIMERS-1:0][MAX_CH-1:0][CHM_W-1:0] ch_mode_i = '0;

  always #20 ref_clk_i = ~ref_clk_i;

  always_comb begin
    ch_pin_i = pin_rnd;
    ch_pin_i[1][1:0] = {enc_b, enc_a};
  end

  quad_encoder_model enc (
    .ref_clk_i, .step_i(enc_step), .back_i(enc_back), .a_o(enc_a), .b_o(enc_b)
  );
  multi_channel_timer_set dut (
    .ref_clk_i, .reset_i, .dbg_halt_i, .enable_i, .freeze_en_i, .one_pulse_i, .count_mode_i,
    .slave_mode_i, .trig_sel_i, .prescale_i, .reload_i, .compare_i, .ch_mode_i, .dead_time_i,
    .ch_pin_i, .ch_out_o, .ch_out_n_o, .capture_o, .count_o, .dir_down_o, .update_o, .dma_req_o
  );

  // ------------------------------
  // helpers
  // ------------------------------
  task automatic check(input logic [MAX_W-1:0] seen, input logic [MAX_W-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(negedge ref_clk_i);
  endtask

  // capped so a dead timer shows up as a wrong period
  task automatic wait_upd(input int t);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (update_o[t] !== 1'b1 && n < 2000);
  endtask

  function automatic int unsigned period(input int m, input int unsigned r, p);
    return (m == 2 ? r : r + 1) * (p + 1);
  endfunction

  // reload 9, dead time 2, counted over two update intervals
  function automatic int unsigned on_cycles(input int m, input int unsigned c, input bit comp);
    int unsigned hi;
    hi = (m == 2) ? 2 * c - 1 : c;
    if (comp) hi = (m == 2 ? 18 : 10) - hi;
    return (m == 2 ? 1 : 2) * (hi - 2);
  endfunction

  // ------------------------------
  // tests
  // ------------------------------
  initial begin
    n = $urandom(63904);
    tick(8);
    reset_i = 1'b0;
    tick(1);
    check(count_o[1], '0);
    check(MAX_W'(update_o | dma_req_o), '0);
    $display("reset test done");
    for (int m = 0; m < 3; m++) begin
      enable_i = '0;
      pin_rnd = (NUM_TIMERS * MAX_CH)'($urandom);
      for (int t = 0; t < NUM_TIMERS; t++) begin
        count_mode_i[t] = MODE_W'(m);
        reload_i[t] = $urandom_range(9, 1);
        prescale_i[t] = PSC_W'($urandom_range(3, 0));
      end
      tick(1);
      enable_i = '1;
      for (int t = 0; t < NUM_TIMERS; t++) begin
        wait_upd(t);
        check(dma_req_o[t], t != 3);
        if (t < 3 && m == 1) check(count_o[t], reload_i[t]);
        wait_upd(t);
        check(n, period(t < 3 ? m : 0, reload_i[t], prescale_i[t]));
      end
      $display("count mode %0d test done", m);
    end
    freeze_en_i = NUM_TIMERS'($urandom) | 6'h01;
    dbg_halt_i = 1'b1;
    tick(2);
    snap = count_o;
    tick(6);
    for (int t = 0; t < NUM_TIMERS; t++) begin
      if (freeze_en_i[t]) check(count_o[t], snap[t]);
    end
    dbg_halt_i = 1'b0;
    $display("freeze test done");
    for (int m = 0; m < 3; m += 2) begin
      count_mode_i[0] = MODE_W'(m);
      reload_i[0] = 32'h0000_0009;
      prescale_i[0] = '0;
      dead_time_i[0] = 8'h02;
      ch_mode_i[0] = {MAX_CH{2'h3}};
      compare_i[0] = {32'h0, 32'($urandom_range(7, 3)), 32'h0000_000A, 32'($urandom_range(7, 3))};
      hi_m = '{default: 0};
      hi_n = '{default: 0};
      tick(40);
      repeat (2 * period(m, 9, 0)) begin
        tick(1);
        for (int c = 0; c < MAX_CH; c++) begin
          hi_m[c] += ch_out_o[0][c];
          hi_n[c] += ch_out_n_o[0][c];
        end
      end
      for (int c = 0; c < 3; c += 2) begin
        check(hi_m[c], on_cycles(m, compare_i[0][c], 1'b0));
        check(hi_n[c], on_cycles(m, compare_i[0][c], 1'b1));
      end
      check(hi_m[1], 2 * period(m, 9, 0));
      check(hi_m[3] + hi_n[3], '0);
      $display("pwm mode %0d test done", m);
    end
    enable_i[2:1] = 2'h0;
    slave_mode_i[1] = 3'h4;
    slave_mode_i[2] = 3'h3;
    trig_sel_i[2] = 3'h3;
    count_mode_i[2:1] = '0;
    reload_i[2:1] = {2{32'h0000_0100}};
    reload_i[3] = 32'h0000_0007;
    prescale_i[3] = '0;
    tick(1);
    enable_i[2:1] = 2'h3;
    tick(2);
    snap = count_o;
    enc_step = 1'b1;
    tick(8);
    enc_step = 1'b0;
    enc_back = 1'b1;
    repeat (4) begin
      enc_step = 1'b1;
      tick(1);
      enc_step = 1'b0;
      tick(2);
    end
    tick(5);
    check(count_o[1], snap[1] + 2);
    wait_upd(3);
    tick(3);
    snap = count_o;
    repeat (3) wait_upd(3);
    tick(3);
    check(count_o[2], snap[2] + 3);
    enable_i[4] = 1'b0;
    one_pulse_i[4] = 1'b1;
    tick(1);
    enable_i[4] = 1'b1;
    wait_upd(4);
    tick(20);
    check(count_o[4], '0);
    enable_i[3] = 1'b0;
    pin_rnd[3][0] = 1'b0;
    ch_mode_i[3][0] = 2'h1;
    tick(4);
    snap = count_o;
    pin_rnd[3][0] = 1'b1;
    tick(4);
    check(capture_o[3][0], snap[3]);
    $display("link, encoder and one pulse test done");
    results();
  end

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_mismatch++;
    results();
  end
endmodule // multi_channel_timer_set_tb
`default_nettype wire
